/* logic/sec_cfg.svh */
`ifndef SEC_CFG_SVH
`define SEC_CFG_SVH
// register byte offsets
`define SEC_OF_SRC  8'h00
`define SEC_OF_OUT  8'h04
`define SEC_OF_PID  8'h08
`define SEC_OF_UNIT 8'h0C
`define SEC_OF_ALM  8'h10
`define SEC_OF_STAT 8'h14
`define SEC_OF_IST  8'h18
`define SEC_OF_IMSK 8'h1C
`define SEC_OF_CTRL 8'h20
// reset values
`define SEC_RST_PB  8'h10
`define SEC_RST_TI  8'h40
// error codes
`define SEC_E_NONE  8'h00
`define SEC_E_SAME1 8'h01
`define SEC_E_SAME2 8'h02
`define SEC_E_DIF   8'h03
`define SEC_E_COOL  8'h04
`define SEC_E_FMT   8'h05
`define SEC_E_ALM   8'h06
`define SEC_E_DWL   8'h07
`define SEC_E_FUNC  8'h0A
`define SEC_E_RNG   8'h0B
`define SEC_E_NEX   8'h0C
`define SEC_E_RO    8'h0E
`define SEC_E_VAL   8'h0F
`define SEC_E_TUNE  8'h1A
// host link
`define SEC_FN_RD   8'h03
`define SEC_FN_WR   8'h06
`define SEC_CA_STAT 8'h0A
`define SEC_CA_TOP  8'h0F
// alarm function codes
`define SEC_AF_NONE 4'h0
`define SEC_AF_DWL  4'h1
`define SEC_AF_DLO  4'h2
`define SEC_AF_DHI  4'h5
`endif

/* logic/sec_checker.sv */
`timescale 1ns/10ps
// Behaviour
// - input one as both value and set point source gives code 1
// - input two as both value and set point source gives code 2
// - difference value with input set point gives code 3
// - cooling second output with direct action or zero PID: code 4
// - mixed units or decimals with both inputs combined: code 5
// - second output on alarm two with no alarm function: code 6
// - dwell timer on both alarm functions gives code 7
// - no alarm drive on second output when alarm two is none
// - unsupported host function code answers code 10
// - host address beyond range answers code 11
// - in-range address with no parameter answers code 12
// - host write to read-only or protected data answers code 14
// - host write of out-of-range value answers code 15
// - failed auto-tuning reports code 26
`include "sec_cfg.svh"
module sec_checker
    import sec_pkg::*;
(
    // clock and reset
    input  logic        clk,
    input  logic        rstn,
    // register bus
    input  logic [7:0]  avs_address,
    input  logic        avs_read,
    input  logic        avs_write,
    input  logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic        avs_waitrequest,
    // host link request
    input  logic        req_valid,
    input  logic [7:0]  req_func,
    input  logic [7:0]  req_addr,
    input  logic [15:0] req_data,
    // host link answer
    output logic        resp_valid,
    output logic [7:0]  resp_code,
    output logic [15:0] resp_data,
    // plant side
    input  logic        autotune_fail,
    input  logic        alarm_two_request,
    output logic        alarm_two_drive,
    output logic [7:0]  error_code,
    output logic        irq
);
    sec_top_st_t s_q, s_d;
    logic [7:0]  setup_code;
    logic [15:0] hv;
    logic        cm_we;
    logic [3:0]  cm_wa;
    logic [15:0] cm_wd;
    logic        bus_req;
    logic        bus_ack;
    logic [31:0] wd;

    assign bus_req = avs_read | avs_write;
    assign bus_ack = bus_req & ~s_q.wreq;
    assign wd      = avs_writedata;

    sec_setup_check u_setup (
        .clk                      (clk),
        .rstn                     (rstn),
        .process_value_source     (s_q.pvs),
        .setpoint_source          (s_q.sps),
        .second_output_role       (s_q.role2),
        .direct_action            (s_q.dir),
        .proportional_band_one    (s_q.band1),
        .proportional_band_two    (s_q.band2),
        .integral_time_one        (s_q.integ1),
        .integral_time_two        (s_q.integ2),
        .input_one_unit           (s_q.unit1),
        .input_two_unit           (s_q.unit2),
        .input_one_decimal_places (s_q.dec1),
        .input_two_decimal_places (s_q.dec2),
        .alarm_one_function       (s_q.afn1),
        .alarm_two_function       (s_q.afn2),
        .setup_code               (setup_code)
    );

    sec_comm_check u_comm (
        .clk           (clk),
        .rstn          (rstn),
        .req_valid     (req_valid),
        .req_func      (req_func),
        .req_addr      (req_addr),
        .req_data      (req_data),
        .write_protect (s_q.prot),
        .read_value    (hv),
        .resp_valid    (resp_valid),
        .resp_code     (resp_code),
        .resp_data     (resp_data),
        .wr_en         (cm_we),
        .wr_addr       (cm_wa),
        .wr_data       (cm_wd)
    );

    always_comb begin
        logic [31:0] rv;
        logic [2:0]  ev;
        logic [2:0]  clr;
        logic        tclr;
        rv   = 32'h0;
        ev   = 3'h0;
        clr  = 3'h0;
        tclr = 1'b0;
        s_d  = s_q;
        // host read value
        case (req_addr)
            8'h00:   hv = {14'h0, s_q.pvs};
            8'h01:   hv = {14'h0, s_q.sps};
            8'h02:   hv = {14'h0, s_q.role2};
            8'h03:   hv = {15'h0, s_q.dir};
            8'h04:   hv = {8'h0, s_q.band1};
            8'h05:   hv = {8'h0, s_q.band2};
            8'h06:   hv = {8'h0, s_q.integ1};
            8'h07:   hv = {8'h0, s_q.integ2};
            8'h08:   hv = {12'h0, s_q.afn1};
            8'h09:   hv = {12'h0, s_q.afn2};
            8'h0A:   hv = {8'h0, s_q.code};
            default: hv = 16'h0000;
        endcase
        // bus read value
        case (avs_address)
            `SEC_OF_SRC:  rv = {26'h0, s_q.sps, 2'h0, s_q.pvs};
            `SEC_OF_OUT:  rv = {27'h0, s_q.dir, 2'h0, s_q.role2};
            `SEC_OF_PID:  rv = {s_q.integ2, s_q.integ1,
                                s_q.band2, s_q.band1};
            `SEC_OF_UNIT: rv = {18'h0, s_q.dec2, 2'h0, s_q.dec1,
                                2'h0, s_q.unit2, 2'h0, s_q.unit1};
            `SEC_OF_ALM:  rv = {20'h0, s_q.afn2, 4'h0, s_q.afn1};
            `SEC_OF_STAT: rv = {15'h0, s_q.tune, s_q.comm, s_q.code};
            `SEC_OF_IST:  rv = {29'h0, s_q.ist};
            `SEC_OF_IMSK: rv = {29'h0, s_q.imsk};
            `SEC_OF_CTRL: rv = {30'h0, s_q.prot, 1'b0};
            default:      rv = 32'h0;
        endcase
        // one wait cycle, then the answer
        s_d.wreq = ~(bus_req & s_q.wreq);
        if (bus_req & s_q.wreq) begin
            s_d.rdata = avs_read ? rv : 32'h0;
        end
        if (bus_ack & avs_write) begin
            case (avs_address)
                `SEC_OF_SRC: begin
                    s_d.pvs = wd[1:0];
                    s_d.sps = wd[5:4];
                end
                `SEC_OF_OUT: begin
                    s_d.role2 = wd[1:0];
                    s_d.dir   = wd[4];
                end
                `SEC_OF_PID: begin
                    s_d.band1  = wd[7:0];
                    s_d.band2  = wd[15:8];
                    s_d.integ1 = wd[23:16];
                    s_d.integ2 = wd[31:24];
                end
                `SEC_OF_UNIT: begin
                    s_d.unit1 = wd[1:0];
                    s_d.unit2 = wd[5:4];
                    s_d.dec1  = wd[9:8];
                    s_d.dec2  = wd[13:12];
                end
                `SEC_OF_ALM: begin
                    s_d.afn1 = wd[3:0];
                    s_d.afn2 = wd[11:8];
                end
                `SEC_OF_IST:  clr = wd[2:0];
                `SEC_OF_IMSK: s_d.imsk = wd[2:0];
                `SEC_OF_CTRL: begin
                    tclr     = wd[0];
                    s_d.prot = wd[1];
                end
                default: ;
            endcase
        end
        // accepted host writes land after a bus write
        if (cm_we) begin
            case (cm_wa)
                4'h0:    s_d.pvs    = cm_wd[1:0];
                4'h1:    s_d.sps    = cm_wd[1:0];
                4'h2:    s_d.role2  = cm_wd[1:0];
                4'h3:    s_d.dir    = cm_wd[0];
                4'h4:    s_d.band1  = cm_wd[7:0];
                4'h5:    s_d.band2  = cm_wd[7:0];
                4'h6:    s_d.integ1 = cm_wd[7:0];
                4'h7:    s_d.integ2 = cm_wd[7:0];
                4'h8:    s_d.afn1   = cm_wd[3:0];
                4'h9:    s_d.afn2   = cm_wd[3:0];
                default: ;
            endcase
        end
        // tuning failure flag, set wins over clear
        s_d.tune = (s_q.tune & ~tclr) | autotune_fail;
        ev[2]    = autotune_fail & ~s_q.tune;
        ev[1]    = resp_valid & (resp_code != `SEC_E_NONE);
        ev[0]    = (setup_code != `SEC_E_NONE) &
                   (setup_code != s_q.prev);
        s_d.prev = setup_code;
        if (resp_valid) begin
            s_d.comm = resp_code;
        end
        s_d.ist  = (s_q.ist & ~clr) | ev;
        s_d.irq  = |(s_d.ist & s_d.imsk);
        // setup faults outrank the tuning code
        if (setup_code != `SEC_E_NONE) begin
            s_d.code = setup_code;
        end else if (s_q.tune) begin
            s_d.code = `SEC_E_TUNE;
        end else begin
            s_d.code = `SEC_E_NONE;
        end
        // alarm two drive gated by its function
        s_d.alm = alarm_two_request &
                  (s_q.role2 == SEC_O2_ALM) &
                  (s_q.afn2 != `SEC_AF_NONE);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q        <= '0;
            s_q.wreq   <= 1'b1;
            s_q.band1  <= `SEC_RST_PB;
            s_q.band2  <= `SEC_RST_PB;
            s_q.integ1 <= `SEC_RST_TI;
            s_q.integ2 <= `SEC_RST_TI;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata    = s_q.rdata;
    assign avs_waitrequest = s_q.wreq;
    assign alarm_two_drive = s_q.alm;
    assign error_code      = s_q.code;
    assign irq             = s_q.irq;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_same_one: assert property (
        s_q.pvs == SEC_PV_ONE && s_q.sps == SEC_SP_ONE
        |=> setup_code == `SEC_E_SAME1)
        else $error("input one clash not coded 1");
    chk_same_two: assert property (
        s_q.pvs == SEC_PV_TWO && s_q.sps == SEC_SP_TWO
        |=> setup_code == `SEC_E_SAME2)
        else $error("input two clash not coded 2");
    chk_diff_src: assert property (
        s_q.pvs[1] && (s_q.sps == SEC_SP_ONE ||
        s_q.sps == SEC_SP_TWO)
        |=> setup_code == `SEC_E_DIF)
        else $error("difference source not coded 3");
    chk_cool_role: assert property (
        s_q.role2 == SEC_O2_COOL && (s_q.dir ||
        s_q.band1 == 8'h00 || s_q.band2 == 8'h00 ||
        s_q.integ1 == 8'h00 || s_q.integ2 == 8'h00)
        |=> setup_code != `SEC_E_NONE &&
            setup_code <= `SEC_E_COOL)
        else $error("cooling fault not coded");
    chk_unit_fmt: assert property (
        s_q.unit1 != s_q.unit2 && s_q.pvs[1]
        |=> setup_code != `SEC_E_NONE &&
            setup_code <= `SEC_E_FMT)
        else $error("unit mismatch not coded");
    chk_alarm_none: assert property (
        s_q.role2 == SEC_O2_ALM && s_q.afn2 == `SEC_AF_NONE
        |=> setup_code != `SEC_E_NONE &&
            setup_code <= `SEC_E_ALM)
        else $error("alarm role fault not coded");
    chk_dwell_both: assert property (
        s_q.afn1 == `SEC_AF_DWL && s_q.afn2 == `SEC_AF_DWL
        |=> setup_code != `SEC_E_NONE &&
            setup_code <= `SEC_E_DWL)
        else $error("dual dwell not coded");
    chk_alarm_gate: assert property (
        alarm_two_drive |-> $past(alarm_two_request) &&
        $past(s_q.afn2) != `SEC_AF_NONE)
        else $error("alarm drive without function");
    chk_bad_func: assert property (
        req_valid && req_func != `SEC_FN_RD &&
        req_func != `SEC_FN_WR
        |=> resp_valid && resp_code == `SEC_E_FUNC)
        else $error("bad function not answered 10");
    chk_addr_range: assert property (
        req_valid && req_func == `SEC_FN_RD &&
        req_addr > `SEC_CA_TOP
        |=> resp_valid && resp_code == `SEC_E_RNG)
        else $error("range error not answered 11");
    chk_no_param: assert property (
        req_valid && req_func == `SEC_FN_RD &&
        req_addr > `SEC_CA_STAT && req_addr <= `SEC_CA_TOP
        |=> resp_code == `SEC_E_NEX)
        else $error("missing parameter not answered 12");
    chk_read_only: assert property (
        req_valid && req_func == `SEC_FN_WR &&
        req_addr == `SEC_CA_STAT
        |=> resp_code == `SEC_E_RO ##1 $stable(s_q.code))
        else $error("read-only write not answered 14");
    chk_val_range: assert property (
        req_valid && req_func == `SEC_FN_WR && !s_q.prot &&
        req_addr == 8'h03 && req_data > 16'h0001
        |=> resp_code == `SEC_E_VAL ##1 $stable(s_q.dir))
        else $error("bad value not answered 15");
    chk_tune_code: assert property (
        autotune_fail ##1 setup_code == `SEC_E_NONE
        |=> error_code == `SEC_E_TUNE)
        else $error("tuning failure not coded 26");
    chk_err_hold: assert property (
        resp_valid && resp_code != `SEC_E_NONE && !avs_write
        |=> $stable({s_q.pvs, s_q.sps, s_q.role2, s_q.dir,
            s_q.band1, s_q.band2, s_q.integ1, s_q.integ2,
            s_q.afn1, s_q.afn2}))
        else $error("errored request wrote a parameter");

    cov_fmt: cover property (setup_code == `SEC_E_FMT);
    cov_host_wr: cover property (cm_we && resp_valid);
    cov_irq: cover property (!irq ##1 irq);
endmodule

/* logic/sec_comm_check.sv */
`timescale 1ns/10ps
`include "sec_cfg.svh"
module sec_comm_check
    import sec_pkg::*;
(
    // clock and reset
    input  logic        clk,
    input  logic        rstn,
    // request from the link
    input  logic        req_valid,
    input  logic [7:0]  req_func,
    input  logic [7:0]  req_addr,
    input  logic [15:0] req_data,
    // device side
    input  logic        write_protect,
    input  logic [15:0] read_value,
    // answer and parameter write
    output logic        resp_valid,
    output logic [7:0]  resp_code,
    output logic [15:0] resp_data,
    output logic        wr_en,
    output logic [3:0]  wr_addr,
    output logic [15:0] wr_data
);
    sec_cm_st_t  s_q, s_d;
    logic [15:0] lim;
    logic        is_wr;

    always_comb begin
        s_d   = s_q;
        is_wr = (req_func == `SEC_FN_WR);
        case (req_addr)
            8'h00:                      lim = 16'h0003;
            8'h01, 8'h02:               lim = 16'h0002;
            8'h03:                      lim = 16'h0001;
            8'h04, 8'h05, 8'h06, 8'h07: lim = 16'h00FF;
            8'h08, 8'h09:               lim = 16'h000F;
            default:                    lim = 16'h0000;
        endcase
        s_d.rv = req_valid;
        s_d.we = 1'b0;
        if (req_valid) begin
            s_d.rd = 16'h0000;
            s_d.wa = req_addr[3:0];
            s_d.wd = req_data;
            if (!is_wr && req_func != `SEC_FN_RD) begin
                s_d.rc = `SEC_E_FUNC;
            end else if (req_addr > `SEC_CA_TOP) begin
                s_d.rc = `SEC_E_RNG;
            end else if (req_addr > `SEC_CA_STAT) begin
                s_d.rc = `SEC_E_NEX;
            end else if (is_wr && (write_protect ||
                req_addr == `SEC_CA_STAT)) begin
                s_d.rc = `SEC_E_RO;
            end else if (is_wr && req_data > lim) begin
                s_d.rc = `SEC_E_VAL;
            end else begin
                // only a clean request may change a parameter
                s_d.rc = `SEC_E_NONE;
                s_d.we = is_wr;
                s_d.rd = is_wr ? 16'h0000 : read_value;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign resp_valid = s_q.rv;
    assign resp_code  = s_q.rc;
    assign resp_data  = s_q.rd;
    assign wr_en      = s_q.we;
    assign wr_addr    = s_q.wa;
    assign wr_data    = s_q.wd;
endmodule

/* logic/sec_pkg.sv */
package sec_pkg;
    typedef enum logic [1:0] {
        SEC_PV_ONE, SEC_PV_TWO, SEC_PV_D12, SEC_PV_D21
    } sec_pv_t;
    typedef enum logic [1:0] {
        SEC_SP_LOC, SEC_SP_ONE, SEC_SP_TWO, SEC_SP_RSV
    } sec_sp_t;
    typedef enum logic [1:0] {
        SEC_O2_NONE, SEC_O2_COOL, SEC_O2_ALM, SEC_O2_RSV
    } sec_o2_t;
    typedef struct packed {
        logic [7:0] code;
    } sec_su_st_t;
    typedef struct packed {
        logic        rv;
        logic [7:0]  rc;
        logic [15:0] rd;
        logic        we;
        logic [3:0]  wa;
        logic [15:0] wd;
    } sec_cm_st_t;
    typedef struct packed {
        logic        wreq;
        logic [31:0] rdata;
        logic [1:0]  pvs, sps, role2;
        logic        dir;
        logic [7:0]  band1, band2, integ1, integ2;
        logic [1:0]  unit1, unit2, dec1, dec2;
        logic [3:0]  afn1, afn2;
        logic        prot, tune;
        logic [2:0]  ist, imsk;
        logic        irq, alm;
        logic [7:0]  code, prev, comm;
    } sec_top_st_t;
endpackage

/* logic/sec_setup_check.sv */
`timescale 1ns/10ps
`include "sec_cfg.svh"
module sec_setup_check
    import sec_pkg::*;
(
    // clock and reset
    input  logic       clk,
    input  logic       rstn,
    // configuration
    input  logic [1:0] process_value_source,
    input  logic [1:0] setpoint_source,
    input  logic [1:0] second_output_role,
    input  logic       direct_action,
    input  logic [7:0] proportional_band_one,
    input  logic [7:0] proportional_band_two,
    input  logic [7:0] integral_time_one,
    input  logic [7:0] integral_time_two,
    input  logic [1:0] input_one_unit,
    input  logic [1:0] input_two_unit,
    input  logic [1:0] input_one_decimal_places,
    input  logic [1:0] input_two_decimal_places,
    input  logic [3:0] alarm_one_function,
    input  logic [3:0] alarm_two_function,
    // result
    output logic [7:0] setup_code
);
    sec_su_st_t s_q, s_d;
    logic       pv_dif, sp_in, a1_dual, a2_dual, fmt_ne, no_pid;

    always_comb begin
        pv_dif  = (process_value_source == SEC_PV_D12) |
                  (process_value_source == SEC_PV_D21);
        sp_in   = (setpoint_source == SEC_SP_ONE) |
                  (setpoint_source == SEC_SP_TWO);
        a1_dual = (alarm_one_function >= `SEC_AF_DLO) &
                  (alarm_one_function <= `SEC_AF_DHI);
        a2_dual = (alarm_two_function >= `SEC_AF_DLO) &
                  (alarm_two_function <= `SEC_AF_DHI);
        fmt_ne  = (input_one_unit != input_two_unit) |
            (input_one_decimal_places != input_two_decimal_places);
        no_pid  = (proportional_band_one == 8'h00) |
                  (proportional_band_two == 8'h00) |
                  (integral_time_one == 8'h00) |
                  (integral_time_two == 8'h00);
        s_d = s_q;
        // lowest code wins
        if (process_value_source == SEC_PV_ONE &&
            setpoint_source == SEC_SP_ONE) begin
            s_d.code = `SEC_E_SAME1;
        end else if (process_value_source == SEC_PV_TWO &&
            setpoint_source == SEC_SP_TWO) begin
            s_d.code = `SEC_E_SAME2;
        end else if (pv_dif && sp_in) begin
            s_d.code = `SEC_E_DIF;
        end else if (second_output_role == SEC_O2_COOL &&
            (direct_action || no_pid)) begin
            s_d.code = `SEC_E_COOL;
        end else if (fmt_ne &&
            (pv_dif || sp_in || a1_dual || a2_dual)) begin
            s_d.code = `SEC_E_FMT;
        end else if (second_output_role == SEC_O2_ALM &&
            alarm_two_function == `SEC_AF_NONE) begin
            s_d.code = `SEC_E_ALM;
        end else if (alarm_one_function == `SEC_AF_DWL &&
            alarm_two_function == `SEC_AF_DWL) begin
            s_d.code = `SEC_E_DWL;
        end else begin
            s_d.code = `SEC_E_NONE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign setup_code = s_q.code;
endmodule

/* tb/sec_host.sv */
`timescale 1ns/10ps
module sec_host (
    // clock
    input  logic        clk,
    // request
    output logic        req_valid,
    output logic [7:0]  req_func,
    output logic [7:0]  req_addr,
    output logic [15:0] req_data,
    // answer
    input  logic        resp_valid,
    input  logic [7:0]  resp_code,
    input  logic [15:0] resp_data
);
    initial begin
        req_valid = 1'b0;
        req_func  = 8'hFF;
        req_addr  = 8'hFF;
        req_data  = 16'hFFFF;
    end
    // one request, then wait for the one-cycle answer
    task automatic xfer(input logic [7:0] f, input logic [7:0] a,
        input logic [15:0] d, output logic [7:0] c, output logic [15:0] r);
        c = 8'hXX;
        r = 16'hXXXX;
        @(posedge clk);
        req_valid <= 1'b1;
        req_func  <= f;
        req_addr  <= a;
        req_data  <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        req_func  <= ~f;
        req_addr  <= ~a;
        req_data  <= ~d;
        for (int n = 0; n < 8; n++) begin
            @(posedge clk);
            if (resp_valid === 1'b1) begin
                c = resp_code;
                r = resp_data;
                break;
            end
        end
    endtask
endmodule

/* tb/tb_sec_checker.sv */
`timescale 1ns/10ps
`include "sec_cfg.svh"
module tb_sec_checker;
    logic        clk = 0, rstn = 0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 0, avs_write = 0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic        avs_waitrequest, req_valid, resp_valid;
    logic [7:0]  req_func, req_addr, resp_code, hc;
    logic [15:0] req_data, resp_data, hd;
    logic        autotune_fail = 0, alarm_two_request = 1;
    logic        alarm_two_drive, irq;
    logic [7:0]  error_code;
    int          err_count = 0, n_tests = 0;
    always #20 clk = ~clk;
    sec_checker i_dut (.clk(clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .req_valid(req_valid),
        .req_func(req_func), .req_addr(req_addr), .req_data(req_data),
        .resp_valid(resp_valid), .resp_code(resp_code),
        .resp_data(resp_data), .autotune_fail(autotune_fail),
        .alarm_two_request(alarm_two_request),
        .alarm_two_drive(alarm_two_drive), .error_code(error_code),
        .irq(irq));
    sec_host i_host (.clk(clk), .req_valid(req_valid), .req_func(req_func),
        .req_addr(req_addr), .req_data(req_data), .resp_valid(resp_valid),
        .resp_code(resp_code), .resp_data(resp_data));
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= ~w;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic host(logic [7:0] f, a, logic [15:0] d, logic [7:0] e);
        i_host.xfer(f, a, d, hc, hd);
        chk("host code", e, hc);
    endtask
    task automatic t_setup();
        logic [7:0]  ta [14] = '{`SEC_OF_SRC, `SEC_OF_OUT, `SEC_OF_SRC,
            `SEC_OF_SRC, `SEC_OF_SRC, `SEC_OF_UNIT, `SEC_OF_ALM,
            `SEC_OF_UNIT, `SEC_OF_ALM, `SEC_OF_OUT, `SEC_OF_OUT,
            `SEC_OF_PID, `SEC_OF_OUT, `SEC_OF_PID};
        logic [31:0] td [14] = '{32'h10, 32'h02, 32'h21, 32'h12, 32'h02,
            32'h01, 32'h0101, 32'h00, 32'h0200, 32'h11, 32'h01,
            32'h40400010, 32'h00, 32'h40401010};
        logic [7:0]  te [14] = '{8'h01, 8'h01, 8'h02, 8'h03, 8'h06, 8'h05,
            8'h05, 8'h07, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00, 8'h00};
        logic [13:0] tv = 14'b00000111000000;
        bus(0, `SEC_OF_PID, 0);
        chk("pid reset", 32'h40401010, rd);
        for (int i = 0; i < 14; i++) begin
            bus(1, ta[i], td[i]);
            repeat (3) @(posedge clk);
            chk("error_code", {24'h0, te[i]}, {24'h0, error_code});
            chk("drive", {31'h0, tv[i]}, {31'h0, alarm_two_drive});
            if (tv[i]) begin
                alarm_two_request <= 1'b0;
                repeat (2) @(posedge clk);
                chk("drive off", 0, alarm_two_drive);
                alarm_two_request <= 1'b1;
            end
            bus(0, `SEC_OF_STAT, 0);
            chk("stat code", {24'h0, te[i]}, {24'h0, rd[7:0]});
        end
        $display("test setup done");
    endtask
    task automatic t_host();
        host(8'h04, 8'h00, 0, `SEC_E_FUNC);
        host(`SEC_FN_RD, 8'h20, 0, `SEC_E_RNG);
        host(`SEC_FN_RD, 8'h0C, 0, `SEC_E_NEX);
        host(`SEC_FN_WR, 8'h0A, 0, `SEC_E_RO);
        host(`SEC_FN_WR, 8'h00, 4, `SEC_E_VAL);
        host(`SEC_FN_WR, 8'h00, 1, 0);
        host(`SEC_FN_WR, 8'h01, 3, `SEC_E_VAL);
        host(`SEC_FN_RD, 8'h00, 0, 0);
        chk("read a0", 16'h1, hd);
        host(`SEC_FN_RD, 8'h01, 0, 0);
        chk("read a1", 16'h0, hd);
        bus(1, `SEC_OF_CTRL, 2);
        host(`SEC_FN_WR, 8'h03, 0, `SEC_E_RO);
        bus(0, `SEC_OF_STAT, 0);
        chk("stat host", 8'h0E, rd[15:8]);
        bus(1, `SEC_OF_CTRL, 0);
        host(`SEC_FN_WR, 8'h00, 0, 0);
        host(`SEC_FN_WR, 8'h03, 2, `SEC_E_VAL);
        $display("test host done");
    endtask
    task automatic t_irq();
        bus(1, `SEC_OF_IST, 7);
        bus(1, `SEC_OF_IMSK, 2);
        host(8'h00, 8'h00, 0, `SEC_E_FUNC);
        @(posedge clk);
        chk("irq set", 1, irq);
        bus(0, `SEC_OF_IST, 0);
        chk("istat", 2, rd);
        bus(1, `SEC_OF_IST, 2);
        @(posedge clk);
        chk("irq clr", 0, irq);
        autotune_fail <= 1'b1;
        @(posedge clk);
        autotune_fail <= 1'b0;
        repeat (3) @(posedge clk);
        chk("tune code", `SEC_E_TUNE, error_code);
        chk("irq mask", 0, irq);
        bus(0, `SEC_OF_IST, 0);
        chk("istat tune", 4, rd);
        bus(1, `SEC_OF_CTRL, 1);
        repeat (3) @(posedge clk);
        chk("tune clr", 0, error_code);
        bus(0, 8'h40, 0);
        chk("unmapped", 0, rd);
        $display("test irq done");
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_setup();
        t_host();
        t_irq();
        print_verdict();
    end
endmodule
